/* inc/hpsc_pkg.sv */
// shared constants and types for the hot-plug slot capability and control
// block; assumes byte addresses in the downstream port's config space
package hpsc_pkg;

   // config space byte offsets, one dword each
   localparam logic [7:0]  CAP_OFFSET     = 8'ha4;
   localparam logic [7:0]  CTL_OFFSET     = 8'ha8;

   // capability field positions
   localparam int          CAP_NUM_LSB    = 19;
   localparam int          CAP_LOCK_BIT   = 18;
   localparam int          CAP_NOCC_BIT   = 17;
   localparam int          CAP_SCALE_LSB  = 15;
   localparam int          CAP_VALUE_LSB  = 7;
   localparam int          CAP_PCP_BIT    = 1;

   // control field positions
   localparam int          CTL_LINK_BIT   = 12;
   localparam int          CTL_LOCK_BIT   = 11;
   localparam int          CTL_POWER_BIT  = 10;
   localparam int          CTL_PLED_LSB   = 8;
   localparam int          CTL_ALED_LSB   = 6;
   localparam int          CTL_HPI_BIT    = 5;
   localparam int          CTL_CCI_BIT    = 4;

   // reset values
   localparam logic [31:0] CAP_RESET      = 32'h0000_0060;
   localparam logic [15:0] CTL_RESET      = 16'h07c0;

   // indicator codes and power limit scale codes
   localparam logic [1:0]  LED_ON         = 2'h1;
   localparam logic [1:0]  LED_BLINK      = 2'h2;
   localparam logic [1:0]  LED_OFF        = 2'h3;
   localparam logic [1:0]  SCALE_ONE      = 2'h0;
   localparam logic [1:0]  SCALE_TENTH    = 2'h1;
   localparam logic [1:0]  SCALE_HUNDREDTH = 2'h2;

   // device power states
   localparam logic [1:0]  PSTATE_D0      = 2'h0;

   // timing
   localparam int          CLK_HZ         = 25_000_000;
   localparam int          LOCK_PULSE_MS  = 100;
   localparam int          TURN_OFF_MS    = 100;
   localparam int          LOCK_PULSE_CYC = LOCK_PULSE_MS * (CLK_HZ / 1000);
   localparam int          TURN_OFF_CYC   = TURN_OFF_MS * (CLK_HZ / 1000);
   localparam int          TIMER_W        = 22;

   // message pending slots, lowest index sent first
   localparam int          PEND_OFF       = 0;
   localparam int          PEND_LIMIT     = 1;
   localparam int          PEND_PLED      = 2;
   localparam int          PEND_ALED      = 3;

   typedef enum logic [1:0] {
      MSG_TURN_OFF, MSG_POWER_LIMIT, MSG_POWER_LED, MSG_ATTN_LED
   } hpsc_msg_kind_type;

   typedef enum logic [1:0] {PWR_OFF, SLOT_POWER_ENABLE_PIN, PWR_DRAIN} hpsc_pwr_type;

   typedef struct packed {
      logic              valid;
      hpsc_msg_kind_type kind;
      logic [9:0]        arg;   // {scale, value} or indicator code
   } hpsc_msg_type;

   typedef struct packed {
      logic        write;
      logic        read;
      logic [7:0]  addr;
      logic [3:0]  byteEn;
      logic [31:0] data;
   } hpsc_cfg_req_type;

   // slot status flags kept by the status register outside
   typedef struct packed {
      logic presence;
      logic latch;
      logic fault;
      logic button;
   } hpsc_events_type;

   typedef struct packed {
      logic [TIMER_W-1:0] count;
      logic               busy;
      logic               done;
   } hpsc_timer_state_type;

   typedef struct packed {
      logic         strapHpc;
      logic         strapPcp;
      logic [1:0]   scale;
      logic [7:0]   value;
      logic         limitWritten;
      logic         linkEn;
      hpsc_pwr_type pwr;
      logic [1:0]   pled;
      logic [1:0]   aled;
      logic         hpiEn;
      logic         cciEn;
      logic [3:0]   evtEn;
      logic [3:0]   pend;
      hpsc_msg_type msg;
      logic [31:0]  rdData;
      logic         rdValid;
      logic         cmdPulse;
      logic         cmdFlag;
      logic         linkFlag;
      logic         linkPrev;
      logic         irq;
      logic         wake;
   } hpsc_state_type;

   // maximum slot power in milliwatts from scale and value
   function automatic logic [17:0] hpsc_limit_mw(input logic [1:0] scale,
                                                 input logic [7:0] value);
      logic [17:0] v;
      v = {10'h000, value};
      unique case (scale)
         SCALE_ONE:       hpsc_limit_mw = 18'(v * 18'd1000);
         SCALE_TENTH:     hpsc_limit_mw = 18'(v * 18'd100);
         SCALE_HUNDREDTH: hpsc_limit_mw = 18'(v * 18'd10);
         default:         hpsc_limit_mw = v;
      endcase
   endfunction

endpackage

/* core/hpsc_pulse_timer.sv */
// one-shot timer: busy stands for exactly CYCLES clocks after start
// assumes CYCLES fits the package timer width and is at least one
`timescale 1ns/1ps
module hpsc_pulse_timer
   import hpsc_pkg::*;
#(
   parameter int CYCLES = 2_500_000
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic start,
   input  wire logic cancel,
   // status
   output logic      busy,
   output logic      done
);
   hpsc_timer_state_type state_reg;
   hpsc_timer_state_type state_next;

   // start wins over cancel so a fresh request is never dropped
   always_comb begin
      state_next = state_reg;
      state_next.done = 1'b0;
      if (rst) begin
         state_next = '0;
      end else if (start) begin
         state_next.count = TIMER_W'(CYCLES - 1);
         state_next.busy = 1'b1;
      end else if (cancel) begin
         state_next.busy = 1'b0;
      end else if (state_reg.busy) begin
         if (state_reg.count == '0) begin
            state_next.busy = 1'b0;
            state_next.done = 1'b1;
         end else begin
            state_next.count = state_reg.count - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      state_reg <= state_next;
   end

   assign busy = state_reg.busy;
   assign done = state_reg.done;
endmodule

/* core/hpsc_slot_regs.sv */
// slot capability and slot control registers of one downstream port
// assumes config accesses arrive as one-cycle strobes with byte enables;
// slot status flags and general control bits live in other registers
//
// Notes on behaviour
// - slot number read-only in bits 31:19
// - interlock-present bit 18 from general control
// - no-command-completed bit reads zero
// - scale codes: 1.0, 0.1, 0.01, 0.001
// - eight-bit power limit value, watts times scale
// - limit written once, only that first write sends message
// - eeprom loads limit fields; reset restores defaults
// - cap bits 6:0 mirror general control 14:8
// - hotplug-able, power-switch defaults from straps
// - no power switch forces early power on
// - bit 12 enables link change interrupt
// - interlock write one gives 100 ms pulse
// - bit 10 power state, one means off
// - power off waits for ack or 100 ms when hotplugWakeMsgEnable is set
// - power led field drives pin, reads back
// - attention led field drives pin, reads back
// - changed led field sends indicator message
// - bit 5 is hot-plug interrupt master enable
// - command completion interrupt needs three enables
// - bits 3:0 enable event interrupt and wake
// - low power states need wake enable too
// - control bits 15:13 read zero, ignore writes
// - command done flag set when ready again
// - link change flag set on change, cleared
`timescale 1ns/1ps
module hpsc_slot_regs
   import hpsc_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_PULSE_CYC,
   parameter int OFF_CYCLES  = TURN_OFF_CYC
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // config space access
   input  wire hpsc_cfg_req_type  cfgReq,
   output logic [31:0]            cfgRdData,
   output logic                   cfgRdValid,
   // values held by neighbouring registers
   input  wire logic [12:0]       slotNumber,
   input  wire logic              interlockPresent,
   input  wire logic [6:0]        genCapBits,
   input  wire logic              genCtlLoaded,
   input  wire logic [1:0]        portStrapPins,
   input  wire logic              hotplugWakeMsgEnable,
   input  wire logic              msgInterruptEnable,
   input  wire logic              wakeEventEnable,
   input  wire logic [1:0]        devicePowerState,
   input  wire hpsc_events_type   slotEvents,
   // link state and flag clears
   input  wire logic              linkActiveIndication,
   input  wire logic              linkChangeClear,
   input  wire logic              commandDoneClear,
   // serial configuration memory load
   input  wire logic              eepromLoad,
   input  wire logic [1:0]        eepromScale,
   input  wire logic [7:0]        eepromValue,
   // message port
   output hpsc_msg_type           msgOut,
   input  wire logic              msgReady,
   input  wire logic              turnOffAck,
   // slot pins
   output logic                   slotPowerEnablePin,
   output logic                   earlyPowerEnable,
   output logic [1:0]             powerLedPin,
   output logic [1:0]             attentionLedPin,
   output logic                   interlockPulse,
   // status and notification
   output logic                   commandDoneFlag,
   output logic                   linkChangeFlag,
   output logic                   hotplugIrq,
   output logic                   hotplugWake,
   output logic [17:0]            powerLimitMilliwatt
);
   hpsc_state_type state_reg;
   hpsc_state_type state_next;

   logic [6:0]  capBits;
   logic [31:0] capWord;
   logic [15:0] ctlWord;
   logic [15:0] newCtl;
   logic [31:0] newCap;
   logic        capWrite;
   logic        ctlWrite;
   logic        lockStart;
   logic        offStart;
   logic        offCancel;
   logic        offDone;
   logic        cmdChange;
   logic        anyEvent;

   // capability mirror; straps stand in until general control is loaded
   assign capBits = genCtlLoaded ? genCapBits :
      {state_reg.strapHpc, genCapBits[5:2],
       state_reg.strapPcp, genCapBits[0]};

   // readable images of both registers
   assign capWord = {slotNumber,
                     interlockPresent,
                     1'b0,
                     state_reg.scale, state_reg.value,
                     capBits};
   assign ctlWord = {3'b000,
                     state_reg.linkEn,
                     1'b0,
                     state_reg.pwr == PWR_OFF,
                     state_reg.pled, state_reg.aled,
                     state_reg.hpiEn, state_reg.cciEn,
                     state_reg.evtEn};

   // byte-lane merge of write data over current contents
   assign capWrite = cfgReq.write && cfgReq.addr == CAP_OFFSET;
   assign ctlWrite = cfgReq.write && cfgReq.addr == CTL_OFFSET
                     && (cfgReq.byteEn[0] || cfgReq.byteEn[1]);
   assign newCap = {cfgReq.byteEn[3] ? cfgReq.data[31:24] : capWord[31:24],
                    cfgReq.byteEn[2] ? cfgReq.data[23:16] : capWord[23:16],
                    cfgReq.byteEn[1] ? cfgReq.data[15:8]  : capWord[15:8],
                    cfgReq.byteEn[0] ? cfgReq.data[7:0]   : capWord[7:0]};
   assign newCtl = {cfgReq.byteEn[1] ? cfgReq.data[15:8] : ctlWord[15:8],
                    cfgReq.byteEn[0] ? cfgReq.data[7:0]  : ctlWord[7:0]};

   // a command is an interlock write or a write that changes the power, power led or attention led field
   assign lockStart = ctlWrite && cfgReq.byteEn[1]
                      && newCtl[CTL_LOCK_BIT] && interlockPresent;
   assign cmdChange = ctlWrite && (lockStart
      || newCtl[CTL_POWER_BIT] != ctlWord[CTL_POWER_BIT]
      || newCtl[CTL_PLED_LSB +: 2] != state_reg.pled
      || newCtl[CTL_ALED_LSB +: 2] != state_reg.aled);

   assign offStart  = state_reg.pwr == SLOT_POWER_ENABLE_PIN && ctlWrite
                      && newCtl[CTL_POWER_BIT] && hotplugWakeMsgEnable;
   assign offCancel = state_reg.pwr == PWR_DRAIN && ctlWrite
                      && !newCtl[CTL_POWER_BIT];
   assign anyEvent  = |(state_reg.evtEn & slotEvents);

   // interlock pulse and turn-off timeout share one timer design
   hpsc_pulse_timer #(.CYCLES(LOCK_CYCLES)) lockTimer (
      .clk    (clk),
      .rst    (rst),
      .start  (lockStart && !interlockPulse),
      .cancel (1'b0),
      .busy   (interlockPulse),
      .done   ()
   );

   hpsc_pulse_timer #(.CYCLES(OFF_CYCLES)) offTimer (
      .clk    (clk),
      .rst    (rst),
      .start  (offStart),
      .cancel (offCancel),
      .busy   (),
      .done   (offDone)
   );

   // next state of the whole register bank
   always_comb begin
      state_next = state_reg;
      state_next.rdValid = cfgReq.read;
      state_next.cmdPulse = cmdChange;
      state_next.linkPrev = linkActiveIndication;
      if (cfgReq.read) begin
         unique case (cfgReq.addr)
            CAP_OFFSET: state_next.rdData = capWord;
            CTL_OFFSET: state_next.rdData = {16'h0000, ctlWord};
            default:    state_next.rdData = 32'h0000_0000;
         endcase
      end
      // limit fields: eeprom loads freely, software only once
      if (eepromLoad) begin
         state_next.scale = eepromScale;
         state_next.value = eepromValue;
      end else if (capWrite && !state_reg.limitWritten
                   && |cfgReq.byteEn[2:0]) begin
         state_next.scale = newCap[CAP_SCALE_LSB +: 2];
         state_next.value = newCap[CAP_VALUE_LSB +: 8];
         state_next.limitWritten = 1'b1;
         state_next.pend[PEND_LIMIT] = 1'b1;
      end
      // control fields; bits 15:13 have no storage
      if (ctlWrite) begin
         state_next.linkEn = newCtl[CTL_LINK_BIT];
         state_next.pled = newCtl[CTL_PLED_LSB +: 2];
         state_next.aled = newCtl[CTL_ALED_LSB +: 2];
         state_next.hpiEn = newCtl[CTL_HPI_BIT];
         state_next.cciEn = newCtl[CTL_CCI_BIT];
         state_next.evtEn = newCtl[3:0];
         if (newCtl[CTL_PLED_LSB +: 2] != state_reg.pled) begin
            state_next.pend[PEND_PLED] = 1'b1;
         end
         if (newCtl[CTL_ALED_LSB +: 2] != state_reg.aled) begin
            state_next.pend[PEND_ALED] = 1'b1;
         end
      end
      // slot power sequencing
      unique case (state_reg.pwr)
         PWR_OFF: begin
            if (ctlWrite && !newCtl[CTL_POWER_BIT]) begin
               state_next.pwr = SLOT_POWER_ENABLE_PIN;
            end
         end
         SLOT_POWER_ENABLE_PIN: begin
            if (offStart) begin
               state_next.pwr = PWR_DRAIN;
               state_next.pend[PEND_OFF] = 1'b1;
            end else if (ctlWrite && newCtl[CTL_POWER_BIT]) begin
               state_next.pwr = PWR_OFF;
            end
         end
         PWR_DRAIN: begin
            if (offCancel) begin
               state_next.pwr = SLOT_POWER_ENABLE_PIN;
            end else if (turnOffAck || offDone) begin
               state_next.pwr = PWR_OFF;
            end
         end
         default: state_next.pwr = PWR_OFF;
      endcase
      // message slot refills when empty or taken; new sets kept
      if (!state_reg.msg.valid || msgReady) begin
         state_next.msg.valid = |state_reg.pend;
         if (state_reg.pend[PEND_OFF]) begin
            state_next.msg.kind = MSG_TURN_OFF;
            state_next.msg.arg = 10'h000;
            state_next.pend[PEND_OFF] = 1'b0;
         end else if (state_reg.pend[PEND_LIMIT]) begin
            state_next.msg.kind = MSG_POWER_LIMIT;
            state_next.msg.arg = {state_reg.scale, state_reg.value};
            if (!(capWrite && !state_reg.limitWritten)) begin
               state_next.pend[PEND_LIMIT] = 1'b0;
            end
         end else if (state_reg.pend[PEND_PLED]) begin
            state_next.msg.kind = MSG_POWER_LED;
            state_next.msg.arg = {8'h00, state_reg.pled};
            state_next.pend[PEND_PLED] = 1'b0;
         end else if (state_reg.pend[PEND_ALED]) begin
            state_next.msg.kind = MSG_ATTN_LED;
            state_next.msg.arg = {8'h00, state_reg.aled};
            state_next.pend[PEND_ALED] = 1'b0;
         end
         // a change landing this cycle must not be lost
         if (ctlWrite && newCtl[CTL_PLED_LSB +: 2] != state_reg.pled) begin
            state_next.pend[PEND_PLED] = 1'b1;
         end
         if (ctlWrite && newCtl[CTL_ALED_LSB +: 2] != state_reg.aled) begin
            state_next.pend[PEND_ALED] = 1'b1;
         end
      end
      // sticky flags: the hardware set wins over a clear
      if (commandDoneClear) begin
         state_next.cmdFlag = 1'b0;
      end
      if (state_reg.cmdPulse) begin
         state_next.cmdFlag = 1'b1;
      end
      if (linkChangeClear) begin
         state_next.linkFlag = 1'b0;
      end
      if (linkActiveIndication != state_reg.linkPrev) begin
         state_next.linkFlag = 1'b1;
      end
      // interrupt and wake requests
      state_next.irq = state_reg.hpiEn && msgInterruptEnable
         && ((state_reg.cciEn && state_reg.cmdFlag)
             || (state_reg.linkEn && state_reg.linkFlag)
             || anyEvent);
      state_next.wake = anyEvent && (devicePowerState == PSTATE_D0
                                     || wakeEventEnable);
      if (rst) begin
         state_next = '0;
         state_next.pwr = PWR_OFF;
         state_next.pled = CTL_RESET[CTL_PLED_LSB +: 2];
         state_next.aled = CTL_RESET[CTL_ALED_LSB +: 2];
         state_next.scale = CAP_RESET[CAP_SCALE_LSB +: 2];
         state_next.value = CAP_RESET[CAP_VALUE_LSB +: 8];
         state_next.strapHpc = portStrapPins[1];
         state_next.strapPcp = portStrapPins[0];
         state_next.linkPrev = linkActiveIndication;
      end
   end

   always_ff @(posedge clk) begin
      state_reg <= state_next;
   end

   // outputs
   assign cfgRdData = state_reg.rdData;
   assign cfgRdValid = state_reg.rdValid;
   assign msgOut = state_reg.msg;
   assign slotPowerEnablePin = state_reg.pwr != PWR_OFF;
   assign earlyPowerEnable = !capBits[CAP_PCP_BIT]
                             || slotPowerEnablePin;
   assign powerLedPin = state_reg.pled;
   assign attentionLedPin = state_reg.aled;
   assign commandDoneFlag = state_reg.cmdFlag;
   assign linkChangeFlag = state_reg.linkFlag;
   assign hotplugIrq = state_reg.irq;
   assign hotplugWake = state_reg.wake;
   assign powerLimitMilliwatt =
      hpsc_limit_mw(state_reg.scale, state_reg.value);

   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   nocc_zero_a: assert property (
      $past(cfgReq.read && cfgReq.addr == CAP_OFFSET) |-> !cfgRdData[17])
      else $error("no-command-completed bit read as one");
   ctl_reserved_a: assert property (
      $past(cfgReq.read && cfgReq.addr == CTL_OFFSET)
      |-> cfgRdData[31:13] == '0)
      else $error("control reserved bits not zero");
   early_power_a: assert property (
      !capBits[CAP_PCP_BIT] |-> earlyPowerEnable)
      else $error("early power not forced without power switch");
   limit_once_a: assert property (
      state_reg.limitWritten && !eepromLoad
      |=> $stable({state_reg.scale, state_reg.value}))
      else $error("power limit changed after first write");
   lock_pulse_a: assert property (
      lockStart && !interlockPulse |=> interlockPulse [*8])
      else $error("interlock pulse did not start");
   led_message_a: assert property (
      ctlWrite && newCtl[CTL_PLED_LSB +: 2] != state_reg.pled
      |=> state_reg.pend[PEND_PLED] ##[0:8]
          (msgOut.valid && msgOut.kind == MSG_POWER_LED))
      else $error("power indicator message not issued");
   // power stays on until the turn-off message is in the slot, one to four cycles after it is queued
   drain_hold_a: assert property (
      offStart |=> (slotPowerEnablePin && state_reg.pend[PEND_OFF])
                   ##[1:4] (slotPowerEnablePin && msgOut.valid
                            && msgOut.kind == MSG_TURN_OFF))
      else $error("power dropped before turn-off message");
   link_set_wins_a: assert property (
      linkActiveIndication != state_reg.linkPrev |=> linkChangeFlag)
      else $error("link change flag lost");
   cmd_done_a: assert property (
      cmdChange |=> ##1 commandDoneFlag)
      else $error("command done flag not set");
   irq_gate_a: assert property (
      hotplugIrq |-> $past(state_reg.hpiEn && msgInterruptEnable))
      else $error("interrupt without master enables");
   wake_gate_a: assert property (
      hotplugWake |-> $past(devicePowerState == PSTATE_D0
                            || wakeEventEnable))
      else $error("wake in low power state without enable");
endmodule

/* tb/hpsc_slot_model.sv */
// slot-side model: takes messages on alternate cycles, acks turn-off
// assumes the message port holds its message until it is taken
`timescale 1ns/1ps
module hpsc_slot_model import hpsc_pkg::*; (
   // clock
   input  wire clk,
   // message port
   input  wire hpsc_msg_type msgOut,
   output logic              msgReady,
   output logic              turnOffAck,
   // record of taken messages
   output logic [7:0]        msgCount,
   output hpsc_msg_type      lastMsg
);
   logic [2:0] ackDelay = 3'h0;
   initial {msgReady, turnOffAck, msgCount, lastMsg} = '0;
   // slow taker, so the sender must hold its message meanwhile
   always @(posedge clk) begin
      msgReady <= ~msgReady;
      turnOffAck <= (ackDelay == 3'h1);
      if (ackDelay != 3'h0)
         ackDelay <= ackDelay - 3'h1;
      if (msgOut.valid && msgReady) begin
         msgCount <= msgCount + 8'h01;
         lastMsg <= msgOut;
         if (msgOut.kind == MSG_TURN_OFF)
            ackDelay <= 3'h4;
      end
   end
endmodule

/* tb/hpsc_slot_regs_test.sv */
// self-checking bench for the slot capability and control registers
// assumes a 25 MHz clock and shortened interlock and turn-off counts
`timescale 1ns/1ps
module hpsc_slot_regs_test import hpsc_pkg::*;;
   logic             clk = 0, rst = 1, doneClear = 0;
   hpsc_cfg_req_type cfgReq = '0;
   logic [31:0]      rdData;
   logic             rdValid, ack, ready, powerPin, earlyPower, lockPulse;
   logic             cmdDone, irq, linkFlag, wake;
   logic             capLoaded = 0, lockPresent = 1, linkActive = 0;
   logic             linkClear = 0, wakeEn = 0, eepromLoad = 0;
   logic [1:0]       devState = PSTATE_D0, eepScale = 2'h0;
   logic [7:0]       eepValue = 8'h00;
   hpsc_events_type  slotEvents = '0;
   logic [1:0]       pledPin, aledPin;
   logic [17:0]      limitMw;
   logic [7:0]       msgCount;
   hpsc_msg_type     msgOut, lastMsg;
   int               failures = 0, n_tests = 0, cycles = 0, n;
   always #20 clk = ~clk;
   hpsc_slot_regs #(.LOCK_CYCLES(20), .OFF_CYCLES(20)) hpsc_slot_regs_i (
      .clk(clk), .rst(rst), .cfgReq(cfgReq), .cfgRdData(rdData),
      .cfgRdValid(rdValid), .slotNumber(13'h0a5b),
      .interlockPresent(lockPresent), .genCapBits(7'h55),
      .genCtlLoaded(capLoaded), .portStrapPins(2'h1),
      .hotplugWakeMsgEnable(1'b1), .msgInterruptEnable(1'b1),
      .wakeEventEnable(wakeEn), .devicePowerState(devState),
      .slotEvents(slotEvents), .linkActiveIndication(linkActive),
      .linkChangeClear(linkClear), .commandDoneClear(doneClear),
      .eepromLoad(eepromLoad), .eepromScale(eepScale),
      .eepromValue(eepValue),
      .msgOut(msgOut), .msgReady(ready), .turnOffAck(ack),
      .slotPowerEnablePin(powerPin), .earlyPowerEnable(earlyPower),
      .powerLedPin(pledPin), .attentionLedPin(aledPin),
      .interlockPulse(lockPulse), .commandDoneFlag(cmdDone),
      .linkChangeFlag(linkFlag), .hotplugIrq(irq), .hotplugWake(wake),
      .powerLimitMilliwatt(limitMw));
   hpsc_slot_model hpsc_slot_model_i (.clk(clk), .msgOut(msgOut),
      .msgReady(ready), .turnOffAck(ack), .msgCount(msgCount),
      .lastMsg(lastMsg));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask
   // request stands one edge, is taken there, then is released
   task automatic cfgWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) cfgReq <= {1'b1, 1'b0, a, 4'hf, d};
      @(posedge clk) cfgReq <= '0;
   endtask
   task automatic cfgRead(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk) cfgReq <= {1'b0, 1'b1, a, 4'hf, 32'h0000_0000};
      @(posedge clk) cfgReq <= '0;
      #1 check(rdValid ? rdData : 32'hxxxx_xxxx, exp);
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // a hang ends in a counted mismatch; the run needs about 140 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         summarize;
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 0;
      idle(1);
      // straps stand in until general control is loaded
      check({31'h0, earlyPower}, 32'h0);
      cfgRead(CAP_OFFSET, {13'h0a5b, 2'h2, 10'h000, 7'h17});
      @(posedge clk) capLoaded <= 1'b1;
      #1 check({31'h0, earlyPower}, 32'h1);
      cfgRead(CAP_OFFSET, {13'h0a5b, 2'h2, 10'h000, 7'h55});
      cfgRead(CTL_OFFSET, 32'h0000_07c0);
      cfgWrite(CAP_OFFSET, 32'h0000_a580);
      idle(6);
      check(32'(lastMsg), 32'({1'b1, MSG_POWER_LIMIT, 10'h14b}));
      check(32'(limitMw), 32'h0000_1d4c);
      cfgWrite(CAP_OFFSET, 32'h0001_0800);
      idle(6);
      check(32'(msgCount), 32'h1);
      cfgRead(CAP_OFFSET, {13'h0a5b, 2'h2, 2'h1, 8'h4b, 7'h55});
      cfgWrite(CTL_OFFSET, 32'h0000_e180);
      idle(8);
      check({pledPin, aledPin, powerPin, cmdDone}, 32'h1b);
      check(32'(lastMsg), 32'({1'b1, MSG_ATTN_LED, 10'h002}));
      check(32'(msgCount), 32'h3);
      cfgRead(CTL_OFFSET, 32'h0000_0180);
      cfgWrite(CTL_OFFSET, 32'h0000_01b0);
      idle(4);
      @(posedge clk) doneClear <= 1;
      @(posedge clk) doneClear <= 0;
      idle(3);
      check({31'h0, irq}, 32'h0);
      // link change and button event, first with their enables off
      @(posedge clk) linkActive <= 1'b1;
      slotEvents.button <= 1'b1;
      idle(2);
      check(32'({linkFlag, irq, wake}), 32'h4);
      cfgWrite(CTL_OFFSET, 32'h0000_11b1);
      idle(3);
      check(32'({linkFlag, irq, wake}), 32'h7);
      @(posedge clk) devState <= 2'h3;
      idle(2);
      check(32'({irq, wake}), 32'h2);
      @(posedge clk) wakeEn <= 1'b1;
      linkClear <= 1'b1;
      @(posedge clk) linkClear <= 1'b0;
      idle(2);
      check(32'({linkFlag, wake}), 32'h1);
      cfgWrite(CTL_OFFSET, 32'h0000_09b0);
      #1 n = 0;
      while (lockPulse === 1'b1 && n < 100) begin
         idle(1);
         n++;
      end
      check(n, 20);
      check({31'h0, irq}, 32'h1);
      cfgRead(CTL_OFFSET, 32'h0000_01b0);
      cfgWrite(CTL_OFFSET, 32'h0000_05b0);
      n = 0;
      while (msgCount !== 8'h04 && n < 20) begin
         idle(1);
         n++;
      end
      check(32'({lastMsg.kind, powerPin}), 32'h1);
      idle(10);
      check({31'h0, powerPin}, 32'h0);
      cfgRead(CTL_OFFSET, 32'h0000_05b0);
      // eeprom load may rewrite the limit after the software write
      @(posedge clk) eepromLoad <= 1'b1;
      eepScale <= 2'h3;
      eepValue <= 8'hc8;
      @(posedge clk) eepromLoad <= 1'b0;
      idle(1);
      check(32'(limitMw), 32'h0000_00c8);
      // a second reset restores defaults and frees the one write
      @(posedge clk) rst <= 1'b1;
      lockPresent <= 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      idle(1);
      cfgRead(CAP_OFFSET, {13'h0a5b, 2'h0, 10'h000, 7'h55});
      cfgWrite(CTL_OFFSET, 32'h0000_0fc0);
      idle(3);
      check(32'({lockPulse, cmdDone}), 32'h0);
      cfgWrite(CAP_OFFSET, 32'h0001_0800);
      idle(6);
      check(32'(limitMw), 32'h0000_00a0);
      check(32'(msgCount), 32'h5);
      summarize;
   end
endmodule
